/* hdl/atm_monitor.sv */
`timescale 1ns/1ps
// Function
// - Trigger accepted only after programmed microsecond persistence
// - Trigger, frame start, frame end, transfer end events
// - Full buffer or slow host discards frame
// - Short image or missing HS flags sync loss
// - Oversized image cropped without sync loss
// - Readout mode drives HS from internal timebase
// - One trigger and strobe per camera triple
// - Three cameras packed as C1,C2,C3,unused byte
// - Four selectable pixel output formats
// - Pixel clock range, halved with decimator
// - Time base geometry up to 2048 square
// - Halt until HS; close HS pulses flag loss
// - Common frame reset, then VD per camera
module atm_monitor
    import atm_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    // Trigger groups
    input  wire logic [1:0]  group_trigger_in_pos,
    input  wire logic [1:0]  group_trigger_in_neg,
    output logic      [1:0]  group_flash_out,
    // Cameras
    input  wire logic [1:0]  camera_sample_clock,
    input  wire logic [5:0]  cam_hs_in,
    input  wire logic [5:0]  cam_vs_in,
    input  wire logic [47:0] cam_pix,
    output logic      [5:0]  cam_hs_out,
    output logic      [5:0]  cam_hs_oe_n,
    output logic      [5:0]  cam_vd_out,
    output logic      [5:0]  cam_vd_oe_n,
    output logic      [5:0]  cam_frame_reset,
    // Host path
    input  wire logic        buf_full,
    input  wire logic        host_ready,
    input  wire logic        host_done,
    output logic      [31:0] host_word,
    output logic             host_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    function automatic logic [2:0] cam_no(logic g, logic [1:0] c);
        cam_no = g ? 3'(c + 2'h3) : {1'b0, c};
    endfunction

    function automatic logic [11:0] clamp(logic [11:0] v);
        clamp = (v > GEOM_MAX) ? GEOM_MAX : v;
    endfunction

    logic [65:0]         sy1, sy2;
    logic [1:0]          prv_clk;
    logic [5:0]          prv_hs, prv_vs;
    logic [CTRL_W-1:0]   ctrl;
    logic [7:0]          deb;
    logic [11:0]         width, height, pix_cnt, line_cnt;
    logic [NEV-1:0]      stat, mask, ev;
    logic [15:0]         line_per, min_gap, expo, tmr, tb_cnt, hs_gap;
    logic [5:0]          us_cnt;
    logic [5:0]          dcyc [2];
    logic [7:0]          deb_cnt [2];
    logic [1:0]          fired, trig_ok;
    logic                grp, dec_ph;
    logic [1:0]          cidx;
    logic [31:0]         pk_buf;
    logic [1:0]          pk_n;
    atm_state_t          st;

    // Every trigger and camera level passes two flops first
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sy1 <= '0;
            sy2 <= '0;
        end else begin
            sy1 <= {group_trigger_in_pos, group_trigger_in_neg,
                    camera_sample_clock, cam_hs_in, cam_vs_in, cam_pix};
            sy2 <= sy1;
        end
    end

    logic [1:0]  trig_p, trig_n, pclk, lvl;
    logic [5:0]  hs, vs;
    logic [47:0] pix;
    assign trig_p = sy2[65:64];
    assign trig_n = sy2[63:62];
    assign pclk   = sy2[61:60];
    assign hs     = sy2[59:54];
    assign vs     = sy2[53:48];
    assign pix    = sy2[47:0];
    assign lvl    = trig_p & ~trig_n;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prv_clk <= '0;
            prv_hs  <= '0;
            prv_vs  <= '0;
        end else begin
            prv_clk <= pclk;
            prv_hs  <= hs;
            prv_vs  <= vs;
        end
    end

    logic        master, tb_hs, hs_ev, vs_rise, pix_ev, take, emit, skip;
    logic        los, end_frame;
    logic [2:0]  cur;
    logic [1:0]  fmt;
    logic [7:0]  deb_min, pbyte;
    logic [23:0] gpix;
    logic [31:0] nw;
    assign master  = ctrl[C_MASTER];
    assign fmt     = ctrl[C_FMT +: 2];
    assign cur     = cam_no(grp, cidx);
    assign deb_min = (deb == 8'h00) ? DEB_RST : deb;
    assign tb_hs   = master && (tb_cnt == 16'h0000);
    assign hs_ev   = master ? tb_hs : (hs[cur] & ~prv_hs[cur]);
    assign vs_rise = vs[cur] & ~prv_vs[cur];
    // Decimator halves the effective pixel rate
    assign pix_ev  = (pclk[grp] & ~prv_clk[grp]) &&
                     (!ctrl[C_DECIM] || dec_ph);
    // Cropper: pixels and lines beyond geometry are dropped
    assign take    = pix_ev && st == ST_ACTIVE && line_cnt != 12'h000 &&
                     line_cnt <= height && pix_cnt < width;
    assign gpix    = grp ? pix[47:24] : pix[23:0];
    assign pbyte   = (fmt == FMT_PLANAR)
                   ? gpix[{ctrl[C_PLANE +: 2], 3'h0} +: 8]
                   : pix[{cur, 3'h0} +: 8];
    assign skip    = take && emit && (!host_ready || buf_full);
    assign los     = (hs_gap >= 16'(HS_LOSS_CYC)) ||
                     (hs_ev && hs_gap < min_gap);
    assign end_frame = master ? (hs_ev && line_cnt == height) : vs_rise;

    // Format packer
    always_comb begin
        nw   = pk_buf;
        emit = 1'b0;
        case (fmt)
            FMT_RGB32: begin
                nw   = {8'h00, gpix[23:16], gpix[15:8], gpix[7:0]};
                emit = 1'b1;
            end
            FMT_YUV16: begin
                nw   = pk_n[0] ? {gpix[15:0], pk_buf[15:0]}
                               : {16'h0000, gpix[15:0]};
                emit = pk_n[0];
            end
            default: begin
                nw   = pk_buf | (32'(pbyte) << {pk_n, 3'h0});
                emit = (pk_n == 2'h3);
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pk_buf     <= '0;
            pk_n       <= '0;
            host_word  <= '0;
            host_valid <= 1'b0;
            dec_ph     <= 1'b0;
        end else begin
            host_valid <= take && emit && !skip;
            if (pclk[grp] & ~prv_clk[grp])
                dec_ph <= ~dec_ph;
            if (st != ST_ACTIVE) begin
                pk_buf <= '0;
                pk_n   <= '0;
            end else if (take) begin
                host_word <= nw;
                pk_buf    <= emit ? 32'h0000_0000 : nw;
                pk_n      <= emit ? 2'h0 : 2'(pk_n + 2'h1);
            end
        end
    end

    // Per-group debounce in whole microseconds
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dcyc    <= '{default: '0};
            deb_cnt <= '{default: '0};
            fired   <= '0;
            trig_ok <= '0;
        end else begin
            for (int g = 0; g < 2; g++) begin
                trig_ok[g] <= lvl[g] && !fired[g] && deb_cnt[g] >= deb_min;
                if (!lvl[g]) begin
                    dcyc[g]    <= '0;
                    deb_cnt[g] <= '0;
                    fired[g]   <= 1'b0;
                end else begin
                    if (trig_ok[g])
                        fired[g] <= 1'b1;
                    if (dcyc[g] == 6'(US_CYC - 1)) begin
                        dcyc[g] <= '0;
                        if (deb_cnt[g] != 8'hff)
                            deb_cnt[g] <= 8'(deb_cnt[g] + 8'h01);
                    end else begin
                        dcyc[g] <= 6'(dcyc[g] + 6'h01);
                    end
                end
            end
        end
    end

    // Internal time base, HS gap and microsecond tick
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tb_cnt <= '0;
            hs_gap <= '0;
            us_cnt <= '0;
        end else begin
            tb_cnt <= (!master || tb_cnt >= line_per) ? 16'h0000
                                                      : 16'(tb_cnt + 16'h1);
            hs_gap <= hs_ev ? 16'h0000
                    : (hs_gap == 16'hffff ? hs_gap : 16'(hs_gap + 16'h1));
            us_cnt <= (us_cnt == 6'(US_CYC - 1)) ? 6'h00 : 6'(us_cnt + 6'h1);
        end
    end

    // Acquisition sequencer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st              <= ST_IDLE;
            ev              <= '0;
            grp             <= 1'b0;
            cidx            <= '0;
            tmr             <= '0;
            pix_cnt         <= '0;
            line_cnt        <= '0;
            group_flash_out <= '0;
        end else begin
            ev <= '0;
            case (st)
                ST_IDLE: begin
                    if (ctrl[C_EN] && |trig_ok) begin
                        grp                   <= !trig_ok[0];
                        group_flash_out[!trig_ok[0]] <= 1'b1;
                        ev[EV_TRIG]           <= 1'b1;
                        cidx <= master ? 2'h0 : ctrl[C_CAM +: 2];
                        tmr  <= '0;
                        st   <= master ? ST_EXPOSE : ST_WAITVS;
                    end
                end
                ST_EXPOSE: begin
                    if (us_cnt == 6'h00)
                        tmr <= 16'(tmr + 16'h1);
                    if (tmr >= expo) begin
                        tmr <= '0;
                        st  <= ST_VD;
                    end
                end
                ST_VD: begin
                    tmr <= 16'(tmr + 16'h1);
                    if (tmr == 16'(VD_CYC - 1)) begin
                        st          <= ST_ACTIVE;
                        ev[EV_SOF]  <= 1'b1;
                        pix_cnt     <= '0;
                        line_cnt    <= '0;
                    end
                end
                ST_WAITVS: begin
                    if (los) begin
                        st         <= ST_HALT;
                        ev[EV_LOS] <= 1'b1;
                    end else if (vs_rise) begin
                        st         <= ST_ACTIVE;
                        ev[EV_SOF] <= 1'b1;
                        pix_cnt    <= '0;
                        line_cnt   <= '0;
                    end
                end
                ST_ACTIVE: begin
                    if (los) begin
                        st         <= ST_HALT;
                        ev[EV_LOS] <= 1'b1;
                    end else if (skip) begin
                        st              <= ST_IDLE;
                        ev[EV_SKIP]     <= 1'b1;
                        group_flash_out <= '0;
                    end else if (end_frame) begin
                        if (line_cnt < height) begin
                            st         <= ST_HALT;
                            ev[EV_LOS] <= 1'b1;
                        end else begin
                            st         <= ST_XFER;
                            ev[EV_EOF] <= 1'b1;
                        end
                    end else if (hs_ev) begin
                        pix_cnt <= '0;
                        if (line_cnt <= height)
                            line_cnt <= 12'(line_cnt + 12'h1);
                    end else if (take) begin
                        pix_cnt <= 12'(pix_cnt + 12'h1);
                    end
                end
                ST_XFER: begin
                    if (host_done) begin
                        ev[EV_EOT] <= 1'b1;
                        tmr        <= '0;
                        if (master && cidx != ctrl[C_CAM +: 2]) begin
                            cidx <= 2'(cidx + 2'h1);
                            st   <= ST_VD;
                        end else begin
                            st              <= ST_IDLE;
                            group_flash_out <= '0;
                        end
                    end
                end
                ST_HALT: begin
                    if (hs_ev) begin
                        st              <= ST_IDLE;
                        group_flash_out <= '0;
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // Sync master outputs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cam_hs_out      <= '0;
            cam_hs_oe_n     <= '1;
            cam_vd_out      <= '0;
            cam_vd_oe_n     <= '1;
            cam_frame_reset <= '0;
        end else begin
            cam_hs_out  <= {6{master && tb_cnt < 16'(HS_W_CYC)}};
            cam_hs_oe_n <= {6{!master}};
            cam_vd_oe_n <= {6{!master}};
            cam_vd_out  <= (st == ST_VD) ? 6'(6'h01 << cur) : 6'h00;
            // Frame reset to the whole triple at once
            cam_frame_reset <= (st == ST_EXPOSE && tmr == 16'h0000)
                             ? (grp ? 6'h38 : 6'h07) : 6'h00;
        end
    end

    // Register port and interrupt
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl     <= CTRL_RST;
            deb      <= DEB_RST;
            width    <= WID_RST;
            height   <= HGT_RST;
            mask     <= '0;
            line_per <= LPER_RST;
            min_gap  <= MINGAP_RST;
            expo     <= EXPO_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                A_CTRL: ctrl <= reg_wdata[CTRL_W-1:0];
                A_DEB:  deb  <= reg_wdata[7:0];
                A_GEOM: begin
                    width  <= clamp(reg_wdata[11:0]);
                    height <= clamp(reg_wdata[27:16]);
                end
                A_MASK: mask <= reg_wdata[NEV-1:0];
                A_LINE: begin
                    line_per <= reg_wdata[15:0];
                    min_gap  <= reg_wdata[31:16];
                end
                A_EXPO: expo <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stat      <= '0;
            irq       <= 1'b0;
            reg_rdata <= '0;
        end else begin
            // A new event wins over the read clear
            stat <= ((reg_rd && reg_addr == A_STAT) ? '0 : stat)
                  | ev;
            irq  <= |(stat & mask);
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    A_CTRL:  reg_rdata <= 32'(ctrl);
                    A_DEB:   reg_rdata <= 32'(deb);
                    A_GEOM:  reg_rdata <= {4'h0, height, 4'h0, width};
                    A_STAT:  reg_rdata <= 32'(stat);
                    A_MASK:  reg_rdata <= 32'(mask);
                    A_LINE:  reg_rdata <= {min_gap, line_per};
                    A_EXPO:  reg_rdata <= 32'(expo);
                    A_STATE: reg_rdata <= {4'h0, line_cnt, 9'h000, st};
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    sequence s_vd_start;
        $rose(|cam_vd_out);
    endsequence
    sequence s_vd_hold;
        (|cam_vd_out)[*4] ##1 !(|cam_vd_out);
    endsequence

    a_trig_debounce: assert property (trig_ok[0] |->
        $past(lvl[0]) && deb_cnt[0] >= deb_min && !$past(fired[0]))
        else $error("trigger accepted before debounce time");
    a_event_sticky: assert property ((|ev) |=>
        ((stat & $past(ev)) == $past(ev)))
        else $error("event not held in status");
    a_irq_level: assert property (((stat & mask) != '0) |=> irq)
        else $error("interrupt missing for set status");
    a_skip_abort: assert property (skip && !los |=>
        st == ST_IDLE ##1 stat[EV_SKIP])
        else $error("skipped frame not discarded");
    a_close_hs: assert property (st == ST_ACTIVE && hs_ev &&
        hs_gap < min_gap |=> st == ST_HALT && ev[EV_LOS])
        else $error("close HS pulses not flagged");
    a_crop_nolos: assert property (st == ST_ACTIVE && !los &&
        !skip && end_frame && line_cnt >= height |=>
        st == ST_XFER && !ev[EV_LOS])
        else $error("large image raised sync loss");
    a_halt_wait: assert property (st == ST_HALT && !hs_ev |=>
        st == ST_HALT)
        else $error("acquisition left halt without HS");
    a_vd_pulse: assert property (s_vd_start |-> s_vd_hold)
        else $error("VD pulse width wrong");
    a_master_hs: assert property (master ##1 master |=>
        cam_hs_oe_n == 6'h00)
        else $error("master mode not driving HS");
    a_rgb_pack: assert property (host_valid && fmt == FMT_RGB32 &&
        $past(fmt) == FMT_RGB32 |-> host_word[31:24] == 8'h00)
        else $error("packed word top byte not unused");
    a_sof_order: assert property (ev[EV_SOF] |-> st == ST_ACTIVE)
        else $error("frame start without active state");
endmodule // atm_monitor

/* hdl/atm_pkg.sv */
package atm_pkg;
    // Clock and timing
    localparam int CLK_MHZ     = 40;
    localparam int US_CYC      = CLK_MHZ;
    localparam int HS_LOSS_US  = 100;
    localparam int HS_LOSS_CYC = HS_LOSS_US * CLK_MHZ;
    localparam int VD_CYC      = 4;
    localparam int HS_W_CYC    = 8;
    // Geometry limit of the time base
    localparam logic [11:0] GEOM_MAX = 12'h800;
    // Register word indexes
    localparam logic [3:0] A_CTRL  = 4'h0;
    localparam logic [3:0] A_DEB   = 4'h1;
    localparam logic [3:0] A_GEOM  = 4'h2;
    localparam logic [3:0] A_STAT  = 4'h3;
    localparam logic [3:0] A_MASK  = 4'h4;
    localparam logic [3:0] A_LINE  = 4'h5;
    localparam logic [3:0] A_EXPO  = 4'h6;
    localparam logic [3:0] A_STATE = 4'h7;
    // Control fields
    localparam int C_EN     = 0;
    localparam int C_FMT    = 1;
    localparam int C_MASTER = 3;
    localparam int C_DECIM  = 4;
    localparam int C_CAM    = 5;
    localparam int C_PLANE  = 7;
    localparam int CTRL_W   = 9;
    // Reset values
    localparam logic [8:0]  CTRL_RST   = 9'h000;
    localparam logic [7:0]  DEB_RST    = 8'h01;
    localparam logic [11:0] WID_RST    = 12'h280;
    localparam logic [11:0] HGT_RST    = 12'h1e0;
    localparam logic [15:0] LPER_RST   = 16'h0a00;
    localparam logic [15:0] MINGAP_RST = 16'h0100;
    localparam logic [15:0] EXPO_RST   = 16'h03e8;
    // Event bits
    localparam int EV_TRIG = 0;
    localparam int EV_SOF  = 1;
    localparam int EV_EOF  = 2;
    localparam int EV_EOT  = 3;
    localparam int EV_SKIP = 4;
    localparam int EV_LOS  = 5;
    localparam int NEV     = 6;
    // Pixel formats
    localparam logic [1:0] FMT_MONO8  = 2'h0;
    localparam logic [1:0] FMT_YUV16  = 2'h1;
    localparam logic [1:0] FMT_RGB32  = 2'h2;
    localparam logic [1:0] FMT_PLANAR = 2'h3;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_EXPOSE = 7'h02,
        ST_VD     = 7'h04,
        ST_WAITVS = 7'h08,
        ST_ACTIVE = 7'h10,
        ST_XFER   = 7'h20,
        ST_HALT   = 7'h40
    } atm_state_t;
endpackage

/* test/atm_camera.sv */
`timescale 1ns/1ps
module atm_camera (
    // Bench control
    input  wire logic       go,
    input  wire logic [3:0] lines,
    output logic            busy,
    // Camera outputs, genlocked triple
    output logic            pclk,
    output logic            hs,
    output logic            vs,
    output logic [23:0]     pix
);
    logic [7:0] c1;

    initial begin
        busy = 1'b0;
        pclk = 1'b0;
        hs   = 1'b0;
        vs   = 1'b0;
        pix  = 24'h0;
    end

    // Six pixels a line, two more than the bench geometry, to force cropping
    always @(posedge go) begin
        busy = 1'b1;
        // Offset keeps every pin change clear of the mclk edges
        #5;
        vs = 1'b1;
        #1000 vs = 1'b0;
        #2000;
        for (int l = 1; l <= lines; l++) begin
            hs = 1'b1;
            #1000 hs = 1'b0;
            #1000;
            for (int p = 0; p < 6; p++) begin
                c1 = {l[3:0], p[3:0]};
                pix = {~c1, c1 ^ 8'h5a, c1};
                #75 pclk = 1'b1;
                // Data not held past the hold window
                #75 pix = ~pix;
                #25 pclk = 1'b0;
                #25;
            end
            #6800;
        end
        vs = 1'b1;
        #1000 vs = 1'b0;
        busy = 1'b0;
    end
endmodule // atm_camera

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
    import atm_pkg::*;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [1:0]  trig_pos = 2'h0;
    logic [1:0]  trig_neg = 2'h0;
    logic        buf_full = 1'b0;
    logic        host_ready = 1'b1;
    logic        host_done = 1'b0;
    logic        cam_go = 1'b0;
    logic [3:0]  cam_lines = 4'h0;
    logic [31:0] reg_rdata;
    logic [31:0] host_word;
    logic        irq;
    logic        host_valid;
    logic        busy;
    logic        pclk;
    logic        hs;
    logic        vs;
    logic [23:0] pix;
    logic [1:0]  group_flash_out;
    logic [5:0]  cam_hs_oe_n;
    logic [5:0]  cam_vd_oe_n;
    logic [5:0]  hs_out;
    logic [5:0]  vd_out;
    logic [5:0]  frame_rst;
    logic [5:0]  hs_seen = 6'h00;
    logic [5:0]  vd_seen = 6'h00;
    logic [5:0]  fr_seen = 6'h00;
    logic        rd_d = 1'b0;
    logic [7:0]  rnd = 8'h02;
    logic [31:0] rq[$];
    logic [31:0] hq[$];
    int          err_total = 0;
    int          cmp_count = 0;

    always #12.5 mclk = ~mclk;

    atm_camera atm_camera_inst (.go(cam_go), .lines(cam_lines), .busy(busy),
        .pclk(pclk), .hs(hs), .vs(vs), .pix(pix));

    atm_monitor atm_monitor_inst (.mclk(mclk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .group_trigger_in_pos(trig_pos), .group_trigger_in_neg(trig_neg),
        .group_flash_out(group_flash_out),
        .camera_sample_clock({2{pclk}}), .cam_hs_in({6{hs}}),
        .cam_vs_in({6{vs}}), .cam_pix({2{pix}}), .cam_hs_out(hs_out),
        .cam_hs_oe_n(cam_hs_oe_n), .cam_vd_out(vd_out),
        .cam_vd_oe_n(cam_vd_oe_n), .cam_frame_reset(frame_rst),
        .buf_full(buf_full), .host_ready(host_ready),
        .host_done(host_done), .host_word(host_word),
        .host_valid(host_valid));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Hold a trigger level for n cycles; neg high keeps it unasserted
    task automatic trig(input int n, input logic neg);
        trig_pos[0] <= 1'b1;
        trig_neg[0] <= neg;
        wait_cyc(n);
        trig_pos[0] <= 1'b0;
        trig_neg[0] <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic frame(input logic [3:0] nl);
        int n;
        n = 0;
        cam_lines <= nl;
        cam_go <= 1'b1;
        @(posedge mclk);
        cam_go <= 1'b0;
        @(posedge mclk);
        while (busy !== 1'b0 && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        chk("busy", {31'h0, busy}, 32'h0);
    endtask

    // Expected packed words, cropped to 4 pixels by 2 lines
    task automatic push(input int nl, input logic yuv);
        logic [7:0]  c1;
        logic [15:0] lo;
        lo = 16'h0000;
        for (int l = 1; l <= nl && l <= 2; l++)
            for (int p = 0; p < 4; p++) begin
                c1 = {l[3:0], p[3:0]};
                if (!yuv)
                    hq.push_back({8'h00, ~c1, c1 ^ 8'h5a, c1});
                else if (p[0])
                    hq.push_back({c1 ^ 8'h5a, c1, lo});
                lo = {c1 ^ 8'h5a, c1};
            end
    endtask

    always @(posedge mclk) begin
        if (rd_d)
            chk("reg_rdata", reg_rdata, rq.pop_front());
        if (host_valid === 1'b1)
            chk("host_word", host_word,
                hq.size() ? hq.pop_front() : 'x);
        rd_d <= reg_rd;
        hs_seen <= hs_seen | hs_out;
        vd_seen <= vd_seen | vd_out;
        fr_seen <= fr_seen | frame_rst;
    end

    initial begin
        wait_cyc(40000);
        err_total++;
        stop_test();
    end

    initial begin
        wait_cyc(2);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(A_CTRL, 32'h0);
        rd(A_DEB, 32'h1);
        rd(A_GEOM, 32'h01e0_0280);
        rd(A_LINE, 32'h0100_0a00);
        rd(A_EXPO, 32'h0000_03e8);
        rd(4'h8, 32'h0);
        wr(A_CTRL, 32'h8);
        @(posedge mclk);
        chk("hs_oe_n", {26'h0, cam_hs_oe_n}, 32'h0);
        chk("vd_oe_n", {26'h0, cam_vd_oe_n}, 32'h0);
        wr(A_CTRL, 32'h5);
        wr(A_DEB, 32'h2);
        wr(A_GEOM, 32'h0002_0004);
        wr(A_MASK, 32'h3f);
        chk("hs_oe_n", {26'h0, cam_hs_oe_n}, 32'h3f);
        // Glitches shorter than two microseconds must be dropped
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            trig(10 + rnd[5:0], 1'b0);
        end
        trig(160, 1'b1);
        wait_cyc(10);
        rd(A_STAT, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        trig(120, 1'b0);
        chk("flash", {30'h0, group_flash_out}, 32'h1);
        push(3, 1'b0);
        frame(3);
        chk("irq", {31'h0, irq}, 32'h1);
        host_done <= 1'b1;
        @(posedge mclk);
        host_done <= 1'b0;
        wait_cyc(3);
        rd(A_STAT, 32'h0f);
        wait_cyc(2);
        chk("irq", {31'h0, irq}, 32'h0);
        chk("flash", {30'h0, group_flash_out}, 32'h0);
        // Short image: one line against a height of two, in YUV16
        wr(A_CTRL, 32'h3);
        trig(120, 1'b0);
        push(1, 1'b1);
        frame(1);
        rd(A_STAT, 32'h23);
        frame(1);
        rd(A_STAT, 32'h0);
        chk("flash", {30'h0, group_flash_out}, 32'h0);
        // Full buffer discards the frame; skip is masked off
        wr(A_MASK, 32'h20);
        buf_full <= 1'b1;
        trig(120, 1'b0);
        frame(3);
        buf_full <= 1'b0;
        chk("irq", {31'h0, irq}, 32'h0);
        rd(A_STAT, 32'h13);
        chk("flash", {30'h0, group_flash_out}, 32'h0);
        chk("words", hq.size(), 32'h0);
        // Frame delay readout: cameras 1 and 2 of group 0 in turn
        wr(A_EXPO, 32'h2);
        wr(A_LINE, 32'h0100_0200);
        wr(A_CTRL, 32'h2d);
        host_done <= 1'b1;
        trig(120, 1'b0);
        wait_cyc(3600);
        host_done <= 1'b0;
        rd(A_STAT, 32'h0f);
        chk("frame_rst", {26'h0, fr_seen}, 32'h07);
        chk("vd_out", {26'h0, vd_seen}, 32'h03);
        chk("hs_out", {26'h0, hs_seen}, 32'h3f);
        chk("flash", {30'h0, group_flash_out}, 32'h0);
        stop_test();
    end
endmodule // tb
